/* File: cbp_pkg.sv */
// Purpose: shared constants and types for the cycle-by-cycle pwm latch
// Assumes: single clock domain, synchronous inputs
// Notes: no software-visible registers
package cbp_pkg;
  // latch terminated value: pulse over, drive blocked until next cycle start
  localparam logic LATCH_TERM = 1'b1;
  localparam logic LATCH_RUN = 1'b0;
  // ------------------------------------------------------------
  // output stage modes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    CBP_OUT_LOW,
    CBP_OUT_DRIVE,
    CBP_OUT_HIZ
  } cbp_out_t;
endpackage

/* File: cbp_edge_if.sv */
// Purpose: carries cycle-timing edge events between detector and latch
// Assumes: one clock
// Notes: fall and rise are plain pulses, one cycle wide; level is the raw pin
`timescale 1ns/1ns
`default_nettype none
interface cbp_edge_if;
  logic level;  // timing level straight from the pin, not registered
  logic fall;   // cycle start pulse
  logic rise;   // cycle end pulse
  modport src (output level, output fall, output rise);
  modport dst (input level, input fall, input rise);
endinterface
`default_nettype wire

/* File: cbp_edge_det.sv */
// Purpose: registers the cycle-timing input and flags its edges
// Assumes: input synchronous to clk
// Notes: edges are flagged in the same cycle the pin moves, against the registered level
`timescale 1ns/1ns
`default_nettype none
module cbp_edge_det
  import cbp_pkg::*;
(
  input wire logic clk,          // system clock
  input wire logic rst_n,        // synchronous reset, active low
  input wire logic timing_in,    // cycle_timing_input pin
  cbp_edge_if.src edge_o         // edge events out
);
  logic level_r;
  // ------------------------------------------------------------
  // previous level; reset high so no false rise
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      level_r <= 1'b1;
    end else begin
      level_r <= timing_in;
    end
  end
  // edge decode
  assign edge_o.level = timing_in;
  assign edge_o.fall = level_r & ~timing_in;
  assign edge_o.rise = ~level_r & timing_in;
endmodule
`default_nettype wire

/* File: cbp_pwm_latch.sv */
// Purpose: gating and latch logic of a cycle-by-cycle pwm modulator
// Assumes: comparator trip, lockout and over-temp arrive as digital levels
// Notes: analog scaling lives outside; both variants share this logic
`timescale 1ns/1ns
`default_nettype none
module cbp_pwm_latch
  import cbp_pkg::*;
(
  input wire logic clk,                 // system clock
  input wire logic rst_n,               // synchronous reset, active low
  input wire logic cycle_timing_input,  // timing square wave
  input wire logic comp_trip,           // comparator trip level
  input wire logic supply_lockout,      // supply lockout level
  input wire logic over_temp,           // over-temperature level
  output logic gate_drive_output,       // gate drive level
  output logic gate_drive_oe,           // high while driving the pin
  output logic pulse_active             // latch in run state
);
  cbp_edge_if edges();
  logic latch_r;
  logic latch_nxt;
  logic drv_r;
  logic oe_r;
  logic act_r;
  cbp_out_t mode_nxt;
  wire fault = supply_lockout | over_temp;
  wire gate_on;
  // bookkeeping for the checks below; nothing here reaches a pin
  localparam logic [1:0] PULSE_CNT_ZERO = 2'h0;
  localparam logic [1:0] PULSE_CNT_ONE = 2'h1;
  localparam logic [1:0] PULSE_CNT_MAX = 2'h2;
  logic seen_drv_r;            // drive level as sampled last edge
  logic [1:0] pulse_cnt_r;     // drive pulses since the last cycle start
  logic [1:0] pulse_cnt_nxt;   // next value of the pulse count
  wire drv_rose;               // drive went from low to high

  // ------------------------------------------------------------
  // run-state decode, shared by the gate and the status flag
  // ------------------------------------------------------------
  // one place for the polarity of the latch, so the gate and the
  // status output can never disagree about what run means
  function automatic logic is_run(input logic latch_v);
    return latch_v == LATCH_RUN;
  endfunction

  cbp_edge_det u_edge (
    .clk(clk),
    .rst_n(rst_n),
    .timing_in(cycle_timing_input),
    .edge_o(edges)
  );

  // ------------------------------------------------------------
  // latch next state; reset dominant like the s-r latch it mimics
  // ------------------------------------------------------------
  always_comb begin
    latch_nxt = latch_r;
    if (fault) begin
      latch_nxt = LATCH_TERM;
    end else if (comp_trip) begin
      latch_nxt = LATCH_TERM;
    end else if (edges.fall) begin
      latch_nxt = LATCH_RUN;
    end else if (edges.rise) begin
      latch_nxt = LATCH_TERM;
    end
  end

  // gating: timing high or trip blocks drive, same for both variants
  // the timing level gates the drive directly, so a latch that is still
  // running when the timing wave goes high cannot stretch the pulse
  assign gate_on = is_run(latch_nxt) & ~cycle_timing_input;

  // output stage mode, over-temp first
  always_comb begin
    if (over_temp) begin
      mode_nxt = CBP_OUT_HIZ;
    end else if (supply_lockout) begin
      mode_nxt = CBP_OUT_LOW;
    end else if (gate_on) begin
      mode_nxt = CBP_OUT_DRIVE;
    end else begin
      mode_nxt = CBP_OUT_LOW;
    end
  end

  // ------------------------------------------------------------
  // registered state and outputs
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      latch_r <= LATCH_TERM;
      drv_r <= 1'b0;
      oe_r <= 1'b1;
      act_r <= 1'b0;
    end else begin
      latch_r <= latch_nxt;
      drv_r <= (mode_nxt == CBP_OUT_DRIVE);
      oe_r <= (mode_nxt != CBP_OUT_HIZ);
      act_r <= is_run(latch_nxt);
    end
  end

  assign gate_drive_output = drv_r;
  assign gate_drive_oe = oe_r;
  assign pulse_active = act_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_timing_high_low: assert property (@(posedge clk) disable iff (!rst_n)
    cycle_timing_input |=> !gate_drive_output) else $error("drive high while timing high");
  a_start_drives: assert property (@(posedge clk) disable iff (!rst_n)
    (edges.fall && !comp_trip && !fault) |=> gate_drive_output)
    else $error("no pulse at cycle start");
  a_trip_ends: assert property (@(posedge clk) disable iff (!rst_n)
    comp_trip |=> !gate_drive_output ##1 (!gate_drive_output || $past(edges.fall)))
    else $error("trip did not end pulse");
  a_one_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    ($fell(gate_drive_output) && !cycle_timing_input && !edges.fall)
    |=> !gate_drive_output)
    else $error("second pulse in cycle");
  a_lockout_low: assert property (@(posedge clk) disable iff (!rst_n)
    (supply_lockout && !over_temp) |=> (!gate_drive_output && gate_drive_oe))
    else $error("lockout not low");
  a_overtemp_hiz: assert property (@(posedge clk) disable iff (!rst_n)
    over_temp |=> (!gate_drive_oe && !gate_drive_output)) else $error("over-temp not hiz");
  a_zero_duty: assert property (@(posedge clk) disable iff (!rst_n)
    (edges.fall && comp_trip) |=> !gate_drive_output) else $error("pulse despite trip");
  a_fault_restart: assert property (@(posedge clk) disable iff (!rst_n)
    ($past(fault) && !fault && !edges.fall) |=> !pulse_active)
    else $error("latch not terminated after fault");
  a_run_holds: assert property (@(posedge clk) disable iff (!rst_n)
    (pulse_active && !cycle_timing_input && !comp_trip && !fault && !edges.rise)
    |=> gate_drive_output) else $error("pulse dropped without trip");
  a_rise_ends: assert property (@(posedge clk) disable iff (!rst_n)
    edges.rise |=> !pulse_active) else $error("rising edge left latch running");

  // ------------------------------------------------------------
  // pulse bookkeeping, read by the checks only
  // ------------------------------------------------------------
  // counts rising edges of the drive since the last cycle start;
  // a cycle start clears it, and it saturates so that a runaway
  // shows up as a stuck count instead of wrapping back to legal
  assign drv_rose = gate_drive_output & ~seen_drv_r;

  // next count: a start wins over a rise, they never share an edge
  always_comb begin
    pulse_cnt_nxt = pulse_cnt_r;
    if (edges.fall) begin
      pulse_cnt_nxt = PULSE_CNT_ZERO;
    end else if (drv_rose && (pulse_cnt_r != PULSE_CNT_MAX)) begin
      pulse_cnt_nxt = pulse_cnt_r + PULSE_CNT_ONE;
    end
  end

  // history registers; reset to the idle drive level so no false rise
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      seen_drv_r <= 1'b0;
      pulse_cnt_r <= PULSE_CNT_ZERO;
    end else begin
      seen_drv_r <= gate_drive_output;
      pulse_cnt_r <= pulse_cnt_nxt;
    end
  end

  // ------------------------------------------------------------
  // further checks on the latch and the output stage
  // ------------------------------------------------------------
  // at most one drive pulse between two cycle starts, counted over
  // the whole cycle rather than only right after a falling drive
  a_pulse_count: assert property (@(posedge clk) disable iff (!rst_n)
    pulse_cnt_r != PULSE_CNT_MAX)
    else $error("more than one pulse in a cycle");

  // the end of the low phase drops the drive on the next edge
  // even when the comparator never tripped: the max-duty case
  a_rise_drops: assert property (@(posedge clk) disable iff (!rst_n)
    edges.rise |=> !gate_drive_output)
    else $error("drive kept past cycle end");

  // the drive is only ever on while the latch is in its run state;
  // both flops load on the same edge from the same next state
  a_drive_needs_run: assert property (@(posedge clk) disable iff (!rst_n)
    gate_drive_output |-> pulse_active)
    else $error("drive on with latch terminated");

  // a pulse can only begin one edge after a cycle start was seen;
  // nothing else is allowed to reopen the drive path
  a_rose_after_start: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(gate_drive_output) |-> $past(edges.fall))
    else $error("pulse began without cycle start");

  // a clean cycle start puts the latch into its run state
  a_start_runs: assert property (@(posedge clk) disable iff (!rst_n)
    (edges.fall && !comp_trip && !fault) |=> pulse_active)
    else $error("latch not running after start");

  // a trip terminates the latch itself, not only the gate
  a_trip_stops_run: assert property (@(posedge clk) disable iff (!rst_n)
    comp_trip |=> !pulse_active)
    else $error("latch still running after trip");

  // the latch is only in run state after a low timing level
  a_run_needs_low: assert property (@(posedge clk) disable iff (!rst_n)
    pulse_active |-> $past(!cycle_timing_input))
    else $error("latch running with timing high");

  // lockout alone terminates the latch as well as lowering the pin
  a_lockout_no_run: assert property (@(posedge clk) disable iff (!rst_n)
    supply_lockout |=> !pulse_active)
    else $error("latch running in lockout");

  // any fault leaves the latch terminated, so the output cannot
  // jump high the moment the fault clears in mid-cycle
  a_fault_stops_run: assert property (@(posedge clk) disable iff (!rst_n)
    fault |=> !pulse_active)
    else $error("latch running during fault");

  // a released pin must not also claim to drive high; the weak
  // pull-down outside decides the level while disabled
  a_hiz_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    !gate_drive_oe |-> !gate_drive_output)
    else $error("drive high while released");

  // the pin is released only for over-temperature, never for the
  // lockout or for plain gating
  a_cool_driven: assert property (@(posedge clk) disable iff (!rst_n)
    !over_temp |=> gate_drive_oe)
    else $error("pin released without over-temp");
endmodule
`default_nettype wire

/* File: cbp_mcu_model.sv */
// Purpose: timing wave source in place of the controller
// Assumes: phase lengths of at least 1
// Notes: low share of the wave caps the duty
`timescale 1ns/1ns
`default_nettype none
module cbp_mcu_model (
  input wire logic clk, // clock
  input wire logic rst_n, // reset
  input wire logic [3:0] low_len, // cycles low
  input wire logic [3:0] high_len, // cycles high
  output logic timing // timing wave
);
  logic [3:0] cnt_r;
  // flip after each phase; high kept >= 1 so a fall is seen
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timing <= 1'b1;
      cnt_r <= 4'h0;
    end else if (cnt_r >= (timing ? high_len : low_len)) begin
      timing <= ~timing;
      cnt_r <= 4'h1;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule
`default_nettype wire

/* File: cycle_by_cycle_pwm_latch_tb.sv */
// Purpose: random check of the pwm latch
// Assumes: one cycle of output latency
// Notes: drive level not compared while hi-z
`timescale 1ns/1ns
`default_nettype none
module cycle_by_cycle_pwm_latch_tb;
  import cbp_pkg::*;
  logic clk = 0, rst_n = 0, trip = 0, lock = 0, hot = 0, go = 0;
  logic t, out, oe, act, pt = 1, run = 0, e_out = 0, e_oe = 1;
  logic [3:0] lo_len = 4'h3, hi_len = 4'h1;
  int fails = 0, total_checks = 0, seed = 91, r;
  always #5 clk = ~clk;
  cbp_mcu_model u_mcu (.clk(clk), .rst_n(rst_n), .low_len(lo_len),
    .high_len(hi_len), .timing(t));
  cbp_pwm_latch u_dut (.clk(clk), .rst_n(rst_n), .cycle_timing_input(t),
    .comp_trip(trip), .supply_lockout(lock), .over_temp(hot),
    .gate_drive_output(out), .gate_drive_oe(oe), .pulse_active(act));
  task automatic check(input logic [1:0] seen, input logic [1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // reference latch; old input values seen here
  always @(posedge clk) begin
    if (!rst_n) begin
      pt = 1;
      run = 0;
      e_oe = 1;
    end else begin
      if (hot || lock || trip) run = 0;
      else if (pt && !t) run = 1;
      else if (!pt && t) run = 0;
      pt = t;
      e_oe = !hot;
    end
    e_out = rst_n && run && !t && !lock && !hot;
  end
  // compare mid-cycle, once outputs settle
  always @(negedge clk) begin
    if (go) begin
      check({oe, act}, {e_oe, run});
      if (e_oe) check({1'b0, out}, {1'b0, e_out});
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    go <= 1'b1;
    for (int i = 0; i < 4000; i++) begin
      @(posedge clk);
      r = $random(seed);
      trip <= r[2:0] == 3'h0;
      lock <= lock ^ (r[9:5] == 5'h0);
      hot <= hot ^ (r[14:10] == 5'h0);
      rst_n <= i % 1500 != 1499;
      if (i % 200 == 0) begin
        lo_len <= 4'h1 + 4'(r[18:16]);
        hi_len <= 4'h1 + 4'(r[20:19]);
      end
    end
    test_done();
  end
endmodule
`default_nettype wire
